// *** core/serial_tx.sv ***
// Purpose: asynchronous serial transmitter with one-entry buffer
// Assumes: register port strobes one cycle, read data the cycle after
// Notes: no parity hardware; ninth bit comes from software
//
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/1ps
module serial_tx
	import serial_tx_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// register port
	input wire serial_tx_pkg::reg_req_t reg_req,
	output logic [15:0] rdata,
	// serial pin
	output logic serial_out_pin_o,
	output logic serial_out_pin_oe,
	// status level
	output logic transmit_buffer_empty_flag
);
	import serial_tx_pkg::*;

	typedef enum {ST_IDLE, ST_START, ST_DATA, ST_STOP} tx_state_t;

	localparam int FLAG_DELAY = 2 * CLK_PER_TCY;

	logic [7:0] transmit_control_reg_r;
	logic [7:0] receive_control_reg_r;
	logic [7:0] baud_control_reg_r;
	logic [15:0] baud_div_r;
	logic [8:0] transmit_buffer_r;
	logic buf_full_r;
	logic [3:0] flag_hold_r;
	frame_t transmit_shifter_r;
	tx_state_t state_r;
	logic [3:0] bit_idx_r;
	logic stop_left_r;
	logic line_r;
	logic [15:0] rdata_r;
	logic transmit_enable;
	logic serial_port_enable;
	logic active;
	logic polarity_invert;
	logic load;
	logic tick;
	logic shifter_empty;
	logic buf_wr;
	logic [3:0] last_idx;

	// every property below samples on the system clock, off during reset
	default clocking cb_sys @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	assign transmit_enable = transmit_control_reg_r[BIT_TRANSMIT_ENABLE];
	assign serial_port_enable = receive_control_reg_r[BIT_SERIAL_PORT_ENABLE];
	// all three controls must agree before anything is sent
	assign active = transmit_enable && !transmit_control_reg_r[BIT_SYNC]
		&& serial_port_enable;
	// inversion only means data polarity in asynchronous mode
	assign polarity_invert = baud_control_reg_r[BIT_POL]
		&& !transmit_control_reg_r[BIT_SYNC];
	assign buf_wr = reg_req.wr && (reg_req.addr == OFS_TX_BUF);
	assign shifter_empty = (state_r == ST_IDLE);
	// buffer moves to shifter whenever the shifter is free and the transmitter is active
	assign load = active && buf_full_r && shifter_empty;
	assign last_idx = transmit_shifter_r.nine ? 4'h8 : 4'h7;

	// baud generator held in restart while idle so start is a full period
	serial_baud_gen u_baud
	(
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.restart(shifter_empty),
		.wide_div(baud_control_reg_r[BIT_BRG16]),
		.div(baud_div_r),
		.tick(tick)
	);

	// control registers written by software
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			transmit_control_reg_r <= RST_CTRL;
			receive_control_reg_r <= RST_CTRL;
			baud_control_reg_r <= RST_CTRL;
			baud_div_r <= RST_DIV;
		end
		else if (reg_req.wr)
		begin
			case (reg_req.addr)
				OFS_TX_CTRL: transmit_control_reg_r <= reg_req.wdata[7:0];
				OFS_RX_CTRL: receive_control_reg_r <= reg_req.wdata[7:0];
				OFS_BAUD_CTRL: baud_control_reg_r <= reg_req.wdata[7:0];
				OFS_BAUD_DIV: baud_div_r <= reg_req.wdata;
				default: ;
			endcase
		end
	end

	// one-entry buffer; the ninth bit is software's parity or data
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			transmit_buffer_r <= 9'h000;
			buf_full_r <= 1'b0;
		end
		else if (buf_wr)
		begin
			transmit_buffer_r <= {transmit_control_reg_r[BIT_TX9D],
				reg_req.wdata[7:0]};
			buf_full_r <= 1'b1;
		end
		else if (!active)
			buf_full_r <= 1'b0;
		else if (load)
			buf_full_r <= 1'b0;
	end

	// empty flag held low for two instruction cycles after a write
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			flag_hold_r <= 4'h0;
		else if (buf_wr)
			flag_hold_r <= 4'(FLAG_DELAY - 1);
		else if (flag_hold_r != 4'h0)
			flag_hold_r <= flag_hold_r - 4'h1;
	end
	// no software path writes the flag; it follows enable and buffer
	assign transmit_buffer_empty_flag = transmit_enable && !buf_full_r
		&& (flag_hold_r == 4'h0 || !buf_wr && flag_hold_r == 4'h0);

	// frame sequencer; a load happens the cycle the shifter goes idle
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_r <= ST_IDLE;
			transmit_shifter_r <= '0;
			bit_idx_r <= 4'h0;
			stop_left_r <= 1'b0;
		end
		else if (!active)
			state_r <= ST_IDLE;
		else
		begin
			case (state_r)
				ST_IDLE:
				begin
					if (load)
					begin
						transmit_shifter_r <= '{data: transmit_buffer_r,
							nine: transmit_control_reg_r[BIT_TX9],
							two_stop: transmit_control_reg_r[BIT_STOP2]};
						state_r <= ST_START;
					end
				end
				ST_START:
				begin
					if (tick)
					begin
						bit_idx_r <= 4'h0;
						state_r <= ST_DATA;
					end
				end
				ST_DATA:
				begin
					if (tick)
					begin
						transmit_shifter_r.data <= {1'b0,
							transmit_shifter_r.data[8:1]};
						bit_idx_r <= bit_idx_r + 4'h1;
						if (bit_idx_r == last_idx)
						begin
							stop_left_r <= transmit_shifter_r.two_stop;
							state_r <= ST_STOP;
						end
					end
				end
				ST_STOP:
				begin
					if (tick)
					begin
						if (stop_left_r)
							stop_left_r <= 1'b0;
						else
							state_r <= ST_IDLE;
					end
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// line level with polarity applied, registered for a clean pin
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			line_r <= 1'b1;
		else
		begin
			case (state_r)
				ST_START: line_r <= 1'b0 ^ polarity_invert;
				ST_DATA: line_r <= transmit_shifter_r.data[0]
					^ polarity_invert;
				ST_STOP: line_r <= 1'b1 ^ polarity_invert;
				default: line_r <= 1'b1 ^ polarity_invert;
			endcase
		end
	end
	assign serial_out_pin_o = line_r;
	assign serial_out_pin_oe = serial_port_enable;

	// read data one cycle after the strobe; unmapped reads zero
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			rdata_r <= 16'h0000;
		else if (reg_req.rd)
		begin
			case (reg_req.addr)
				OFS_TX_CTRL: rdata_r <= {8'h00, transmit_control_reg_r};
				OFS_RX_CTRL: rdata_r <= {8'h00, receive_control_reg_r};
				OFS_BAUD_CTRL: rdata_r <= {8'h00, baud_control_reg_r};
				OFS_BAUD_DIV: rdata_r <= baud_div_r;
				OFS_STATUS: rdata_r <= {13'h0000, shifter_empty,
					!shifter_empty, transmit_buffer_empty_flag};
				default: rdata_r <= 16'h0000; // shifter is never readable
			endcase
		end
		else
			rdata_r <= 16'h0000;
	end
	assign rdata = rdata_r;

	// assertions
	AST_IDLE_MARK: assert property (
		$past(state_r == ST_IDLE) && $past(active) && !polarity_invert
		&& $past(!polarity_invert) |-> line_r)
		else $error("idle line not at mark");
	AST_START_SPACE: assert property (
		(state_r == ST_START) && !polarity_invert |=> !line_r)
		else $error("start bit not space");
	AST_STOP_MARK: assert property (
		(state_r == ST_STOP) && !polarity_invert |=> line_r)
		else $error("stop bit not mark");
	AST_DATA_LSB: assert property (
		(state_r == ST_DATA) && !polarity_invert
		|=> line_r == $past(transmit_shifter_r.data[0]))
		else $error("data bit not taken from the shifter low end");
	AST_INVERT_IDLE: assert property (
		(state_r == ST_IDLE) && polarity_invert |=> !line_r)
		else $error("inverted idle line not low");
	AST_LOAD_START: assert property (
		load |=> state_r == ST_START)
		else $error("load did not begin start bit");
	AST_NOT_ACTIVE: assert property (
		!active |=> state_r == ST_IDLE)
		else $error("frame continued while disabled");
	// pin direction follows the written port-enable bit one edge later
	AST_OE: assert property (
		reg_req.wr && reg_req.addr == OFS_RX_CTRL
		|=> serial_out_pin_oe == $past(reg_req.wdata[BIT_SERIAL_PORT_ENABLE]))
		else $error("pin direction not following port enable");
	AST_FLAG_DELAY: assert property (
		buf_wr |=> !transmit_buffer_empty_flag [*7])
		else $error("empty flag changed before two instruction cycles");
	AST_FLAG_EN: assert property (
		!transmit_enable |-> !transmit_buffer_empty_flag)
		else $error("empty flag set while disabled");
	AST_HANDOFF: assert property (
		(state_r == ST_STOP) && tick && !stop_left_r && buf_full_r
		&& active ##1 active |-> load)
		else $error("pending character not loaded after stop");
	AST_TICK_ADV: assert property (
		(state_r == ST_DATA) && !tick && active |=> $stable(bit_idx_r))
		else $error("shifter advanced without baud tick");
	// covers for the main frame shapes
	COV_FRAME: cover property (state_r == ST_STOP ##1 state_r == ST_IDLE);
	COV_BACK2BACK: cover property (state_r == ST_STOP && buf_full_r
		##[1:600] load);
	COV_INVERT: cover property (polarity_invert && state_r == ST_DATA);
	COV_NINE_TWO_STOP: cover property (state_r == ST_STOP
		&& transmit_shifter_r.nine && transmit_shifter_r.two_stop);
endmodule // serial_tx

// *** core/serial_tx_pkg.sv ***
// Purpose: shared constants and types for the async serial transmitter
// Assumes: 25 MHz system clock, instruction cycle of four clocks
// Notes: register offsets are word addresses on the plain register port
package serial_tx_pkg;
	// register offsets
	localparam logic [3:0] OFS_TX_CTRL = 4'h0;
	localparam logic [3:0] OFS_RX_CTRL = 4'h1;
	localparam logic [3:0] OFS_BAUD_CTRL = 4'h2;
	localparam logic [3:0] OFS_BAUD_DIV = 4'h3;
	localparam logic [3:0] OFS_TX_BUF = 4'h4;
	localparam logic [3:0] OFS_STATUS = 4'h5;
	// transmit_control_reg fields
	localparam int BIT_TX9 = 6;
	localparam int BIT_TRANSMIT_ENABLE = 5;
	localparam int BIT_SYNC = 4;
	localparam int BIT_STOP2 = 3;
	localparam int BIT_TX9D = 0;
	// receive_control_reg field
	localparam int BIT_SERIAL_PORT_ENABLE = 7;
	// baud_control_reg fields
	localparam int BIT_POL = 4;
	localparam int BIT_BRG16 = 3;
	// status fields
	localparam int BIT_EMPTY = 0;
	localparam int BIT_BUSY = 1;
	localparam int BIT_SHIFT_EMPTY = 2;
	// reset values
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [15:0] RST_DIV = 16'h0000;
	// timing: one instruction cycle is four system clocks
	localparam int CLK_PER_TCY = 4;
	localparam int FRAME_BITS_MAX = 12;
	// register port request
	typedef struct packed
	{
		logic [3:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;
	// frame handed to the shifter
	typedef struct packed
	{
		logic [8:0] data;
		logic nine;
		logic two_stop;
	} frame_t;
endpackage

// *** core/serial_baud_gen.sv ***
// Purpose: baud tick generator, 8-bit or 16-bit divider of the clock
// Assumes: tick period is (div+1) instruction cycles, only the low byte of div counting in 8-bit mode
// Notes: restarts whenever restart is high so a frame starts aligned
`timescale 1ns/1ps
module serial_baud_gen
	import serial_tx_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// control
	input wire logic restart,
	input wire logic wide_div,
	input wire logic [15:0] div,
	// output
	output logic tick
);
	logic [1:0] tcy_cnt_r;
	logic [15:0] cnt_r;
	logic tcy_en;
	logic [15:0] limit;
	// the two-bit prescaler below only serves a four-clock cycle
	if (CLK_PER_TCY != 4)
	begin : g_tcy_check
		$error("serial_baud_gen serves an instruction cycle of 4 clocks");
	end
	// instruction-cycle enable from the system clock
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			tcy_cnt_r <= 2'h0;
		else if (restart)
			tcy_cnt_r <= 2'h0;
		else
			tcy_cnt_r <= tcy_cnt_r + 2'h1;
	end
	assign tcy_en = (tcy_cnt_r == 2'h3);
	// 8-bit mode ignores the upper divider byte
	assign limit = wide_div ? div : {8'h00, div[7:0]};
	// divider counts instruction cycles
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			cnt_r <= 16'h0000;
		else if (restart)
			cnt_r <= 16'h0000;
		else if (tcy_en)
			cnt_r <= (cnt_r >= limit) ? 16'h0000 : cnt_r + 16'h0001;
	end
	assign tick = tcy_en && (cnt_r >= limit);
endmodule // serial_baud_gen

// *** sim/serial_rx_model.sv ***
// Purpose: remote async receiver model watching the serial line
// Assumes: bit length given in system clocks by the bench
// Notes: samples mid-bit, so a wrong bit length shows as bad data
`timescale 1ns/1ps
module serial_rx_model
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// line and frame format
	input wire logic line,
	input wire logic invert,
	input wire logic nine,
	input wire logic two_stop,
	input wire integer bit_clks,
	// results
	output logic [8:0] rx_data,
	output int rx_count,
	output int rx_errs
);
	logic lvl;
	// logic value of the line with polarity removed
	assign lvl = line ^ invert;
	// start, data lsb first, then stops; passive, never drives back
	// one process owns every result so each has a single driver
	initial
	begin
		rx_data = '0;
		rx_count = 0;
		rx_errs = 0;
		forever
		begin
			@(posedge clk_sys);
			if (rst_n === 1'b1 && lvl === 1'b0)
			begin
				repeat (bit_clks / 2) @(posedge clk_sys);
				if (lvl !== 1'b0)
					rx_errs++;
				rx_data = '0;
				for (int i = 0; i < (nine ? 9 : 8); i++)
				begin
					repeat (bit_clks) @(posedge clk_sys);
					rx_data[i] = lvl;
				end
				for (int s = 0; s < (two_stop ? 2 : 1); s++)
				begin
					repeat (bit_clks) @(posedge clk_sys);
					if (lvl !== 1'b1)
						rx_errs++;
				end
				rx_count++;
			end
		end
	end
endmodule // serial_rx_model

// *** sim/serial_tx_tb.sv ***
// Purpose: self-checking bench for the async serial transmitter
// Assumes: divider 16'h0101 gives 8 clocks a bit in 8-bit mode
// Notes: receiver model decodes every frame sent on the pin
`timescale 1ns/1ps
module serial_tx_tb;
	import serial_tx_pkg::*;
	logic clk_sys;
	logic rst_n;
	reg_req_t reg_req;
	logic [15:0] rdata;
	logic pin_o;
	logic pin_oe;
	logic flag;
	logic invert;
	logic nine;
	logic two_stop;
	int bit_clks;
	logic [8:0] rx_data;
	int rx_count;
	int rx_errs;
	int mismatches;
	int num_checks;
	int n0;
	serial_tx dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_req(reg_req),
		.rdata(rdata), .serial_out_pin_o(pin_o),
		.serial_out_pin_oe(pin_oe), .transmit_buffer_empty_flag(flag));
	serial_rx_model far_end (.clk_sys(clk_sys), .rst_n(rst_n),
		.line(pin_o), .invert(invert), .nine(nine), .two_stop(two_stop),
		.bit_clks(bit_clks), .rx_data(rx_data), .rx_count(rx_count),
		.rx_errs(rx_errs));
	// 25 MHz system clock
	initial
	begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	function automatic logic [15:0] bv(input int b);
		return 16'h0001 << b;
	endfunction
	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp_v);
		num_checks++;
		if (seen !== exp_v)
		begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp_v, seen);
		end
	endtask
	task automatic close_out();
		if (mismatches == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_sys);
		reg_req.wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd_chk(input string what, input logic [3:0] a,
		input logic [15:0] e);
		@(posedge clk_sys);
		reg_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge clk_sys);
		reg_req.rd <= 1'b0;
		@(negedge clk_sys);
		check(what, rdata, e);
	endtask
	// bounded wait for the receiver; a timeout ends the run
	task automatic wait_rx(input int n, input logic [8:0] e);
		for (int k = 0; k < 20000 && rx_count < n; k++)
			@(posedge clk_sys);
		check("frames", 16'(rx_count), 16'(n));
		if (rx_count < n)
			close_out();
		else
		begin
			check("rx data", 16'(rx_data), 16'(e));
			check("rx errors", 16'(rx_errs), 16'h0000);
		end
	endtask
	task automatic send(input logic [15:0] d, input logic [8:0] e);
		wr(OFS_TX_BUF, d);
		wait_rx(rx_count + 1, e);
	endtask
	initial
	begin
		rst_n = 1'b0;
		reg_req = '0;
		invert = 1'b0;
		nine = 1'b0;
		two_stop = 1'b0;
		bit_clks = 8;
		mismatches = 0;
		num_checks = 0;
		repeat (20) @(posedge clk_sys);
		rst_n <= 1'b1;
		check("pin idle", 16'(pin_o), 16'h0001);
		check("pin oe", 16'(pin_oe), 16'h0000);
		check("flag", 16'(flag), 16'h0000);
		rd_chk("unmapped", 4'hF, 16'h0000);
		wr(OFS_RX_CTRL, bv(BIT_SERIAL_PORT_ENABLE));
		wr(OFS_BAUD_DIV, 16'h0101);
		wr(OFS_BAUD_CTRL, 16'h0000);
		check("pin oe", 16'(pin_oe), 16'h0001);
		rd_chk("divider", OFS_BAUD_DIV, 16'h0101);
		wr(OFS_TX_CTRL, bv(BIT_TRANSMIT_ENABLE));
		repeat (2) @(negedge clk_sys);
		check("flag", 16'(flag), 16'h0001);
		rd_chk("status", OFS_STATUS, 16'h0005);
		send(16'h00A5, 9'h0A5);
		// second character waits in the buffer behind the first
		n0 = rx_count;
		wr(OFS_TX_BUF, 16'h00C3);
		wr(OFS_TX_BUF, 16'h003C);
		repeat (2 * CLK_PER_TCY) @(negedge clk_sys);
		check("flag busy", 16'(flag), 16'h0000);
		wait_rx(n0 + 1, 9'h0C3);
		wait_rx(n0 + 2, 9'h03C);
		check("flag", 16'(flag), 16'h0001);
		// wide divider uses all sixteen bits
		wr(OFS_BAUD_CTRL, bv(BIT_BRG16));
		bit_clks = 1032;
		send(16'h0096, 9'h096);
		wr(OFS_BAUD_CTRL, 16'h0000);
		bit_clks = 8;
		nine = 1'b1;
		two_stop = 1'b1;
		wr(OFS_TX_CTRL, bv(BIT_TX9) | bv(BIT_TRANSMIT_ENABLE) | bv(BIT_STOP2) |
			bv(BIT_TX9D));
		send(16'h005A, 9'h15A);
		wr(OFS_TX_CTRL, bv(BIT_TX9) | bv(BIT_TRANSMIT_ENABLE) | bv(BIT_STOP2));
		send(16'h00FF, 9'h0FF);
		nine = 1'b0;
		two_stop = 1'b0;
		wr(OFS_TX_CTRL, bv(BIT_TRANSMIT_ENABLE));
		wr(OFS_BAUD_CTRL, bv(BIT_POL));
		// model polarity flips on the edge that flips the pin, no false start
		@(posedge clk_sys);
		invert <= 1'b1;
		repeat (2) @(negedge clk_sys);
		check("pin inverted", 16'(pin_o), 16'h0000);
		send(16'h0081, 9'h081);
		// clocked mode: no inversion and no asynchronous frame
		wr(OFS_TX_CTRL, bv(BIT_TRANSMIT_ENABLE) | bv(BIT_SYNC));
		@(posedge clk_sys);
		invert <= 1'b0;
		repeat (120) @(posedge clk_sys);
		n0 = rx_count;
		wr(OFS_TX_BUF, 16'h0055);
		repeat (200) @(posedge clk_sys);
		check("pin sync", 16'(pin_o), 16'h0001);
		check("no frame", 16'(rx_count), 16'(n0));
		// drop enable mid-frame
		wr(OFS_BAUD_CTRL, 16'h0000);
		wr(OFS_TX_CTRL, bv(BIT_TRANSMIT_ENABLE));
		wr(OFS_TX_BUF, 16'h0000);
		repeat (30) @(posedge clk_sys);
		wr(OFS_TX_CTRL, 16'h0000);
		repeat (3) @(negedge clk_sys);
		check("pin abandon", 16'(pin_o), 16'h0001);
		check("flag off", 16'(flag), 16'h0000);
		wr(OFS_RX_CTRL, 16'h0000);
		repeat (2) @(negedge clk_sys);
		check("pin oe", 16'(pin_oe), 16'h0000);
		close_out();
	end
endmodule // serial_tx_tb
